// ### gpm_map.svh
// Register indices, field positions, reset values and timing counts of the GPIO block.
`ifndef GPM_MAP_SVH
`define GPM_MAP_SVH
`define GPM_IDX_DATA 5'h00
`define GPM_IDX_DIR 5'h06
`define GPM_IDX_KIND 5'h0c
`define GPM_IDX_MISC 5'h0d
`define GPM_IDX_PFC 5'h0e
`define GPM_IDX_PFD 5'h0f
`define GPM_IDX_ISTS 5'h10
`define GPM_IDX_IMASK 5'h11
`define GPM_IDX_DEB 5'h12
`define GPM_IDX_NONE 5'h1f
`define GPM_PORTS 6
`define GPM_PORT_C 2
`define GPM_PORT_L 5
`define GPM_MISC_PULL 7
`define GPM_DEB_EN 0
`define GPM_IST_TRANS 0
`define GPM_REG_RESET 8'h00
`define GPM_RESP_OKAY 2'h0
`define GPM_RESP_SLVERR 2'h2
`define GPM_CLK_NS 100
`define GPM_SAMPLE_NS 1600
`define GPM_SAMPLE_CYC ((`GPM_SAMPLE_NS + `GPM_CLK_NS - 1) / `GPM_CLK_NS)
`define GPM_STABLE_SAMPLES 4
`endif

// ### gpm_pkg.sv
// Types shared by the GPIO block.
package gpm_pkg;
   typedef enum logic {GPM_DB_IDLE, GPM_DB_WAIT} gpm_db_state_t;
   typedef logic [7:0] gpm_byte_t;
endpackage

// ### gpm_dbnc_if.sv
// Carrier between the GPIO top and the Port-A de-bounce filter.
`timescale 1ns/1ps
interface gpm_dbnc_if;
   logic [7:0] raw;
   logic enable;
   logic [7:0] level;
   logic change;
   modport dev (input raw, input enable, output level, output change);
   modport ctl (output raw, output enable, input level, input change);
endinterface

// ### gpm_debounce.sv
// Port-A de-bounce filter with transition pulse.
`timescale 1ns/1ps
`include "gpm_map.svh"
module gpm_debounce
   import gpm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   gpm_dbnc_if.dev db
);
   localparam logic [4:0] TICK_LAST = 5'(`GPM_SAMPLE_CYC - 1);
   localparam logic [2:0] STABLE = 3'(`GPM_STABLE_SAMPLES);
   gpm_db_state_t state_reg, state_next;
   logic [4:0] tick_reg, tick_next;
   logic [2:0] cnt_reg, cnt_next;
   logic [7:0] cand_reg, cand_next;
   logic [7:0] level_reg, level_next;
   logic change_reg, change_next;
   logic tick;

   assign tick = (tick_reg == TICK_LAST);

   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      cand_next = cand_reg;
      level_next = level_reg;
      tick_next = tick ? 5'h00 : tick_reg + 5'h01;
      if (!db.enable)
      begin
         level_next = db.raw;
         cand_next = db.raw;
         state_next = GPM_DB_IDLE;
      end
      else if (tick)
      begin
         // A level is taken only after it held for every sample of the window.
         case (state_reg)
            GPM_DB_IDLE:
            begin
               if (db.raw != level_reg)
               begin
                  cand_next = db.raw;
                  cnt_next = 3'h1;
                  state_next = GPM_DB_WAIT;
               end
            end
            GPM_DB_WAIT:
            begin
               if (db.raw == level_reg)
                  state_next = GPM_DB_IDLE;
               else if (db.raw != cand_reg)
               begin
                  cand_next = db.raw;
                  cnt_next = 3'h1;
               end
               else if (cnt_reg + 3'h1 >= STABLE)
               begin
                  level_next = cand_reg;
                  state_next = GPM_DB_IDLE;
               end
               else
                  cnt_next = cnt_reg + 3'h1;
            end
            default: state_next = GPM_DB_IDLE;
         endcase
      end
      change_next = (level_next != level_reg);
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_reg <= GPM_DB_IDLE;
         tick_reg <= 5'h00;
         cnt_reg <= 3'h0;
         // Starting from the pin level keeps a false transition pulse away after reset.
         cand_reg <= db.raw;
         level_reg <= db.raw;
         change_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         tick_reg <= tick_next;
         cnt_reg <= cnt_next;
         cand_reg <= cand_next;
         level_reg <= level_next;
         change_reg <= change_next;
      end
   end

   assign db.level = level_reg;
   assign db.change = change_reg;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   deb_stable_a: assert property (db.enable && $past(db.enable) && level_reg != $past(level_reg)
      |-> $past(cnt_reg) == STABLE - 3'h1 && $past(tick))
      else $error("De-bounced level changed before the stable window ended.");
   deb_pulse_a: assert property (level_reg != $past(level_reg) |-> change_reg)
      else $error("Level change gave no transition pulse.");
endmodule

// ### gpm_top.sv
// GPIO block: six eight-bit ports, pulls, muxing, Port-A de-bounce and AXI4-Lite registers.
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "gpm_map.svh"
// Behaviour
// - 48 pins as six eight-bit ports.
// - Direction bit one is output, zero input.
// - Input pins read back the pin level.
// - Input data one pulls up; Port-C zero pulls down.
// - Other ports have no pull-down at all.
// - Misc bit 7 enables group pull-ups.
// - Port-C kind bit gates its pull resistor.
// - Output pins drive and read written data.
// - Port-C kind zero gives open-drain output.
// - Other ports always drive push-pull outputs.
// - Ports C, D, E switch to system functions.
// - Port-L carries display signals while powered.
// - Display unpowered: Port-L outputs its data.
// - Function switching keeps direction and kind.
// - Port-A de-bounce option and transition interrupt.
module gpm_top
   import gpm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [47:0] pad_in,
   output logic [47:0] pad_out,
   output logic [47:0] pad_oe_n,
   output logic [47:0] pull_up_en,
   output logic [7:0] portc_pull_down_en,
   input wire logic [23:0] sys_func_out,
   input wire logic display_power_bit,
   input wire logic [7:0] display_out,
   output logic irq
);
   gpm_byte_t port_data_reg [`GPM_PORTS];
   gpm_byte_t port_data_next [`GPM_PORTS];
   gpm_byte_t pin_direction_reg [`GPM_PORTS];
   gpm_byte_t pin_direction_next [`GPM_PORTS];
   gpm_byte_t portc_kind_select_reg, portc_kind_select_next;
   gpm_byte_t port_misc_control_reg, port_misc_control_next;
   gpm_byte_t portc_function_select_reg, portc_function_select_next;
   gpm_byte_t portd_function_select_reg, portd_function_select_next;
   gpm_byte_t irq_status_reg, irq_status_next;
   gpm_byte_t irq_mask_reg, irq_mask_next;
   gpm_byte_t deb_ctrl_reg, deb_ctrl_next;
   logic aw_hold_reg, aw_hold_next;
   logic [7:0] aw_addr_reg, aw_addr_next;
   logic w_hold_reg, w_hold_next;
   logic [7:0] w_data_reg, w_data_next;
   logic w_lane_reg, w_lane_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic do_write;
   logic [4:0] widx, ridx;
   logic [47:0] dir_flat, data_flat, level_flat, func_sel, drive_val;
   gpm_dbnc_if dbi ();

   // Maps a byte address onto a register index; misaligned or unused gives none.
   function automatic logic [4:0] reg_index(input logic [7:0] addr);
      logic [4:0] idx;
      idx = `GPM_IDX_NONE;
      if (addr[1:0] == 2'h0 && addr[7:2] <= {1'b0, `GPM_IDX_DEB})
         idx = addr[6:2];
      return idx;
   endfunction

   assign dbi.raw = pad_in[7:0];
   assign dbi.enable = deb_ctrl_reg[`GPM_DEB_EN];

   gpm_debounce u_debounce
   (
      .ref_clk (ref_clk),
      .rst_n (rst_n),
      .db (dbi)
   );

   assign s_axi_awready = !aw_hold_reg;
   assign s_axi_wready = !w_hold_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign widx = reg_index(aw_addr_reg);
   assign ridx = reg_index(s_axi_araddr);

   always_comb
   begin
      aw_hold_next = aw_hold_reg;
      aw_addr_next = aw_addr_reg;
      w_hold_next = w_hold_reg;
      w_data_next = w_data_reg;
      w_lane_next = w_lane_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      if (s_axi_awvalid && !aw_hold_reg)
      begin
         aw_hold_next = 1'b1;
         aw_addr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_reg)
      begin
         w_hold_next = 1'b1;
         w_data_next = s_axi_wdata[7:0];
         w_lane_next = s_axi_wstrb[0];
      end
      if (bvalid_reg && s_axi_bready)
         bvalid_next = 1'b0;
      if (do_write)
      begin
         aw_hold_next = 1'b0;
         w_hold_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = (widx == `GPM_IDX_NONE) ? `GPM_RESP_SLVERR : `GPM_RESP_OKAY;
      end
   end

   // Registers that software writes; the status bit alone is also set by hardware.
   always_comb
   begin
      port_data_next = port_data_reg;
      pin_direction_next = pin_direction_reg;
      portc_kind_select_next = portc_kind_select_reg;
      port_misc_control_next = port_misc_control_reg;
      portc_function_select_next = portc_function_select_reg;
      portd_function_select_next = portd_function_select_reg;
      irq_mask_next = irq_mask_reg;
      deb_ctrl_next = deb_ctrl_reg;
      irq_status_next = irq_status_reg;
      if (do_write && w_lane_reg)
      begin
         for (int p = 0; p < `GPM_PORTS; p++)
         begin
            if (widx == `GPM_IDX_DATA + 5'(p))
               port_data_next[p] = w_data_reg;
            if (widx == `GPM_IDX_DIR + 5'(p))
               pin_direction_next[p] = w_data_reg;
         end
         case (widx)
            `GPM_IDX_KIND: portc_kind_select_next = w_data_reg;
            `GPM_IDX_MISC: port_misc_control_next = w_data_reg;
            `GPM_IDX_PFC: portc_function_select_next = w_data_reg;
            `GPM_IDX_PFD: portd_function_select_next = w_data_reg;
            `GPM_IDX_ISTS: irq_status_next = irq_status_reg & ~w_data_reg;
            `GPM_IDX_IMASK: irq_mask_next = w_data_reg;
            `GPM_IDX_DEB: deb_ctrl_next = w_data_reg;
            default: ;
         endcase
      end
      // A transition in the clearing cycle still sets the flag.
      if (dbi.change)
         irq_status_next[`GPM_IST_TRANS] = 1'b1;
   end

   always_comb
   begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (rvalid_reg && s_axi_rready)
         rvalid_next = 1'b0;
      if (s_axi_arvalid && !rvalid_reg)
      begin
         rvalid_next = 1'b1;
         rdata_next = 32'h0000_0000;
         rresp_next = `GPM_RESP_OKAY;
         for (int p = 0; p < `GPM_PORTS; p++)
         begin
            if (ridx == `GPM_IDX_DATA + 5'(p))
               rdata_next[7:0] = (pin_direction_reg[p] & port_data_reg[p])
                  | (~pin_direction_reg[p] & level_flat[8*p +: 8]);
            if (ridx == `GPM_IDX_DIR + 5'(p))
               rdata_next[7:0] = pin_direction_reg[p];
         end
         case (ridx)
            `GPM_IDX_KIND: rdata_next[7:0] = portc_kind_select_reg;
            `GPM_IDX_MISC: rdata_next[7:0] = port_misc_control_reg;
            `GPM_IDX_PFC: rdata_next[7:0] = portc_function_select_reg;
            `GPM_IDX_PFD: rdata_next[7:0] = portd_function_select_reg;
            `GPM_IDX_ISTS: rdata_next[7:0] = irq_status_reg;
            `GPM_IDX_IMASK: rdata_next[7:0] = irq_mask_reg;
            `GPM_IDX_DEB: rdata_next[7:0] = deb_ctrl_reg;
            `GPM_IDX_NONE: rresp_next = `GPM_RESP_SLVERR;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         for (int p = 0; p < `GPM_PORTS; p++)
         begin
            port_data_reg[p] <= `GPM_REG_RESET;
            pin_direction_reg[p] <= `GPM_REG_RESET;
         end
         portc_kind_select_reg <= `GPM_REG_RESET;
         port_misc_control_reg <= `GPM_REG_RESET;
         portc_function_select_reg <= `GPM_REG_RESET;
         portd_function_select_reg <= `GPM_REG_RESET;
         irq_status_reg <= `GPM_REG_RESET;
         irq_mask_reg <= `GPM_REG_RESET;
         deb_ctrl_reg <= `GPM_REG_RESET;
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_hold_reg <= 1'b0;
         w_data_reg <= 8'h00;
         w_lane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `GPM_RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `GPM_RESP_OKAY;
      end
      else
      begin
         port_data_reg <= port_data_next;
         pin_direction_reg <= pin_direction_next;
         portc_kind_select_reg <= portc_kind_select_next;
         port_misc_control_reg <= port_misc_control_next;
         portc_function_select_reg <= portc_function_select_next;
         portd_function_select_reg <= portd_function_select_next;
         irq_status_reg <= irq_status_next;
         irq_mask_reg <= irq_mask_next;
         deb_ctrl_reg <= deb_ctrl_next;
         aw_hold_reg <= aw_hold_next;
         aw_addr_reg <= aw_addr_next;
         w_hold_reg <= w_hold_next;
         w_data_reg <= w_data_next;
         w_lane_reg <= w_lane_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   // Port-E function groups: misc bit 0 for pins 2..0, bit 1 for 5..3, bit 2 for 7..6.
   assign func_sel = {{8{display_power_bit}},
      {2{port_misc_control_reg[2]}}, {3{port_misc_control_reg[1]}},
      {3{port_misc_control_reg[0]}}, portd_function_select_reg,
      portc_function_select_reg, 16'h0000};

   // Pin stage per port; direction and kind stay in force under a function.
   genvar gp;
   generate
      for (gp = 0; gp < `GPM_PORTS; gp++)
      begin : g_port
         assign dir_flat[8*gp +: 8] = pin_direction_reg[gp];
         assign data_flat[8*gp +: 8] = port_data_reg[gp];
         if (gp == 0)
            assign level_flat[7:0] = dbi.level;
         else
            assign level_flat[8*gp +: 8] = pad_in[8*gp +: 8];
         if (gp == `GPM_PORT_L)
            assign drive_val[47:40] = func_sel[40] ? display_out : port_data_reg[gp];
         else if (gp == 0 || gp == 1)
            assign drive_val[8*gp +: 8] = port_data_reg[gp];
         else
            assign drive_val[8*gp +: 8] = (func_sel[8*gp +: 8] & sys_func_out[8*gp-16 +: 8])
               | (~func_sel[8*gp +: 8] & port_data_reg[gp]);
         if (gp == `GPM_PORT_C)
         begin
            // Kind zero is open drain: drive only a low, release the pin for a high.
            assign pad_out[23:16] = drive_val[23:16] & portc_kind_select_reg;
            assign pad_oe_n[23:16] = ~pin_direction_reg[gp]
               | (~portc_kind_select_reg & drive_val[23:16]);
            assign pull_up_en[23:16] = ~pin_direction_reg[gp] & port_data_reg[gp]
               & portc_kind_select_reg;
            assign portc_pull_down_en = ~pin_direction_reg[gp] & ~port_data_reg[gp]
               & portc_kind_select_reg;
         end
         else
         begin
            assign pad_out[8*gp +: 8] = drive_val[8*gp +: 8];
            assign pad_oe_n[8*gp +: 8] = ~pin_direction_reg[gp];
            // No pull-down exists here, so a cleared data bit leaves the pin floating.
            assign pull_up_en[8*gp +: 8] = ~pin_direction_reg[gp] & port_data_reg[gp]
               & {8{port_misc_control_reg[`GPM_MISC_PULL]}};
         end
      end
   endgenerate

   assign irq = |(irq_status_reg & irq_mask_reg);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence wr_port_b;
      do_write && w_lane_reg && widx == `GPM_IDX_DATA + 5'h01;
   endsequence
   sequence rd_port_b_in;
      s_axi_arvalid && s_axi_arready && ridx == `GPM_IDX_DATA + 5'h01
         && pin_direction_reg[1] == 8'h00;
   endsequence

   dir_oe_a: assert property (pad_oe_n[15:0] == ~dir_flat[15:0]
      && pad_oe_n[47:24] == ~dir_flat[47:24])
      else $error("Output enable does not follow direction.");
   in_read_a: assert property (rd_port_b_in |=> rvalid_reg
      && rdata_reg[7:0] == $past(pad_in[15:8]))
      else $error("Input read did not return pin level.");
   pd_portc_a: assert property (portc_pull_down_en
      == (~dir_flat[23:16] & ~data_flat[23:16] & portc_kind_select_reg))
      else $error("Port-C pull-down wrong.");
   pu_group_a: assert property (!port_misc_control_reg[`GPM_MISC_PULL]
      |-> pull_up_en[15:0] == 16'h0000 && pull_up_en[47:24] == 24'h00_0000)
      else $error("Group pull-up active while disabled.");
   out_drive_a: assert property (wr_port_b ##1 pin_direction_reg[1] == 8'hff
      |-> pad_out[15:8] == $past(w_data_reg))
      else $error("Written data not driven.");
   open_drain_a: assert property (dir_flat[16] && !portc_kind_select_reg[0] && drive_val[16]
      |-> pad_oe_n[16] && !pad_out[16])
      else $error("Open-drain pin drove a high.");
   lcd_gpio_a: assert property (!display_power_bit && dir_flat[40]
      |-> pad_out[40] == data_flat[40])
      else $error("Port-L ignores data while display is off.");
   fn_keep_a: assert property ($changed(portd_function_select_reg)
      |-> $stable(pin_direction_reg[3]) && $stable(pad_oe_n[31:24]))
      else $error("Function switch altered direction.");
   trans_irq_a: assert property (dbi.change |=> irq_status_reg[`GPM_IST_TRANS])
      else $error("Transition did not set status.");
   reset_dflt_a: assert property (!$past(rst_n) |-> pad_oe_n == 48'hffff_ffff_ffff
      && pull_up_en == 48'h0000_0000_0000 && portc_pull_down_en == 8'h00)
      else $error("Reset state not input with pulls off.");
endmodule

// ### gpm_pin_model.sv
// Board model of the pads: block drivers, pull resistors and an external keypad.
`timescale 1ns/1ps
module gpm_pin_model (
   input wire logic ref_clk,
   input wire logic [47:0] pad_out,
   input wire logic [47:0] pad_oe_n,
   input wire logic [47:0] pull_up_en,
   input wire logic [7:0] portc_pull_down_en,
   input wire logic [47:0] ext_level,
   input wire logic [47:0] ext_en,
   output logic [47:0] pad_in
);
   logic [47:0] last_reg;
   logic [47:0] pd;
   // A floating pad shows the inverse of its last level, so a stale value never reads as a match.
   always_comb
   begin
      pd = {24'h00_0000, portc_pull_down_en, 16'h0000};
      for (int i = 0; i < 48; i++)
      begin
         if (!pad_oe_n[i])
            pad_in[i] = pad_out[i];
         else if (ext_en[i])
            pad_in[i] = ext_level[i];
         else if (pull_up_en[i])
            pad_in[i] = 1'b1;
         else if (pd[i])
            pad_in[i] = 1'b0;
         else
            pad_in[i] = (last_reg[i] === 1'b1) ? 1'b0 : 1'b1;
      end
   end
   always_ff @(posedge ref_clk)
      last_reg <= pad_in;
endmodule

// ### gpm_top_tb.sv
// Self-checking bench for the GPIO block, driven over AXI4-Lite.
`timescale 1ns/1ps
`include "gpm_map.svh"
module gpm_top_tb;
   localparam logic [7:0] A_DIR = 8'(`GPM_IDX_DIR * 4);
   localparam logic [7:0] A_KIND = 8'(`GPM_IDX_KIND * 4);
   localparam logic [7:0] A_MISC = 8'(`GPM_IDX_MISC * 4);
   localparam logic [7:0] A_PFC = 8'(`GPM_IDX_PFC * 4);
   localparam logic [7:0] A_PFD = 8'(`GPM_IDX_PFD * 4);
   localparam logic [7:0] A_STS = 8'(`GPM_IDX_ISTS * 4);
   localparam logic [7:0] A_MASK = 8'(`GPM_IDX_IMASK * 4);
   localparam logic [7:0] A_DEB = 8'(`GPM_IDX_DEB * 4);
   logic ref_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, disp_pwr, irq;
   logic [7:0] awaddr, araddr, pdn, disp_out;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   logic [47:0] pad_in, pad_out, pad_oe_n, pull_up_en, ext_level, ext_en;
   logic [23:0] sys_func;
   int n_fail = 0;
   int n_compared = 0;

   gpm_top u_gpm_top (.ref_clk(ref_clk), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en),
      .portc_pull_down_en(pdn), .sys_func_out(sys_func), .display_power_bit(disp_pwr),
      .display_out(disp_out), .irq(irq));

   gpm_pin_model u_gpm_pin_model (.ref_clk(ref_clk), .pad_out(pad_out),
      .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en), .portc_pull_down_en(pdn),
      .ext_level(ext_level), .ext_en(ext_en), .pad_in(pad_in));

   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic finish_test;
      $display("Compared %0d, mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         n_fail++;
      end
   endtask

   // Address and data are offered together; each is dropped once the slave has taken it.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h00_0000, d};
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge ref_clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      bready <= 1'b0;
      rsp = bresp;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge ref_clk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      rready <= 1'b0;
      rd = rdata;
      rsp = rresp;
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
      rd_reg(a);
      chk(rd, {40'h00_0000_0000, exp});
   endtask

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      finish_test();
   end

   initial
   begin
      rst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, disp_pwr} = 6'h00;
      {awaddr, araddr, disp_out} = 24'h00_0000;
      wdata = 32'h0000_0000;
      wstrb = 4'hf;
      sys_func = 24'hE7_5A3C;
      ext_en = {48{1'b1}};
      ext_level = 48'h0F1E_2D3C_4B5A;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      chk(pad_oe_n, {48{1'b1}});
      chk(pull_up_en, 48'h0000_0000_0000);
      for (int i = 6; i < 19; i++)
         chk_rd(8'(i * 4), 8'h00);
      for (int p = 0; p < 6; p++)
         chk_rd(8'(p * 4), ext_level[8 * p +: 8]);
      wr(A_MISC, 8'h80);
      for (int p = 0; p < 6; p++)
         wr(8'(p * 4), 8'hFF);
      wr(A_KIND, 8'hF0);
      chk(pull_up_en, 48'hFFFF_FFF0_FFFF);
      chk(pdn, 8'h00);
      wr(8'h08, 8'h33);
      wr(8'h04, 8'h00);
      chk(pull_up_en, 48'hFFFF_FF30_00FF);
      chk(pdn, 8'hC0);
      wr(A_MISC, 8'h00);
      chk(pull_up_en, 48'h0000_0030_0000);
      wr(A_MISC, 8'h80);
      wr(A_KIND, 8'h0F);
      for (int p = 0; p < 6; p++)
      begin
         wr(8'(p * 4), 8'(8'h11 * (p + 1)));
         wr(A_DIR + 8'(p * 4), 8'hFF);
      end
      chk(pad_out, 48'h6655_4403_2211);
      chk(pad_oe_n, 48'h0000_0030_0000);
      chk(pull_up_en, 48'h0000_0000_0000);
      for (int p = 0; p < 6; p++)
         chk_rd(8'(p * 4), 8'(8'h11 * (p + 1)));
      wr(A_KIND, 8'hFF);
      wr(A_PFC, 8'hFF);
      wr(A_PFD, 8'h0F);
      wr(A_MISC, 8'h01);
      chk(pad_out, 48'h6657_4A3C_2211);
      chk(pad_oe_n, 48'h0000_0000_0000);
      wr(A_MISC, 8'h06);
      chk(pad_out[39:32], 8'hE5);
      wr(A_DIR + 8'h0C, 8'h00);
      chk(pad_oe_n, 48'h0000_FF00_0000);
      disp_out <= 8'hC9;
      disp_pwr <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk(pad_out[47:40], 8'hC9);
      disp_pwr <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(pad_out[47:40], 8'h66);
      wr(A_DIR, 8'h00);
      wr(A_DEB, 8'h01);
      wr(A_MASK, 8'h01);
      wr(A_STS, 8'h01);
      chk(irq, 1'b0);
      ext_level[7:0] <= 8'h5B;
      repeat (20) @(posedge ref_clk);
      chk_rd(8'h00, 8'h5A);
      chk(irq, 1'b0);
      repeat (100) @(posedge ref_clk);
      chk_rd(8'h00, 8'h5B);
      chk(irq, 1'b1);
      chk_rd(A_STS, 8'h01);
      wr(A_MASK, 8'h00);
      chk(irq, 1'b0);
      wr(A_MASK, 8'h01);
      chk(irq, 1'b1);
      wr(A_STS, 8'h01);
      chk(irq, 1'b0);
      chk_rd(A_STS, 8'h00);
      wr(8'h4C, 8'hFF);
      chk(rsp, `GPM_RESP_SLVERR);
      chk_rd(8'h4C, 8'h00);
      chk(rsp, `GPM_RESP_SLVERR);
      chk_rd(8'h01, 8'h00);
      chk(rsp, `GPM_RESP_SLVERR);
      finish_test();
   end
endmodule
